//--- bank_integral_filter.sv
// Eight-line integral filter with a per-nibble time constant and a bypass.
// Assumes inputs synchronous to mclk; time constant n means (n+1) filter units.
`include "gpio_defs.svh"
module bank_integral_filter import gpio_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire bank_type   sample,
	input  wire logic       enable,
	input  wire nibble_type tc_low,
	input  wire nibble_type tc_high,
	output bank_type        filt
);
	logic [`FILTER_CNT_W-1:0] cnt_q [8];

	function automatic logic [`FILTER_CNT_W-1:0] threshold(input nibble_type tc);
		threshold = `FILTER_CNT_W'(({6'h00, tc} + 10'h001) * `FILTER_UNIT_CYCLES);
	endfunction

	// While enabled, a bit flips only after its input has differed for the full threshold
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			filt <= `BANK_RESET;
			for (int i = 0; i < 8; i++)
				cnt_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (!enable)
				begin
					filt[i]  <= sample[i];
					cnt_q[i] <= '0;
				end
				else if (sample[i] == filt[i])
					cnt_q[i] <= '0;
				else if (cnt_q[i] + 10'h001 >= threshold(i < 4 ? tc_low : tc_high))
				begin
					filt[i]  <= sample[i];
					cnt_q[i] <= '0;
				end
				else
					cnt_q[i] <= cnt_q[i] + 10'h001;
			end
		end
	end

	// The release edge still samples the reset values, so it starts no check
	a_filter_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
		reset_n && !enable |=> filt == $past(sample))
		else $error("bypassed filter did not pass input through");

	a_glitch_reject: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n) && $past(enable) && $past(enable, 2) && $changed(filt)
		|-> ((filt ^ $past(filt)) & ($past(sample, 2) ^ filt)) == 8'h00)
		else $error("filter output changed on a one-cycle input");

	c_filter_flip: cover property (@(posedge mclk) disable iff (!reset_n)
		enable && $changed(filt));
endmodule

//--- dual_mode_io_port_pins.sv
// Top of the 32-line dual-mode I/O port block with its Avalon-MM register slave.
// Assumes synchronous inputs, a synchronous active-low reset and pins resolved outside from the enables.
`include "gpio_defs.svh"

// Behaviour
// - In host-slave mode the open-drain interrupt pin is pulled low while an unmasked interrupt is pending and released otherwise.
// - In host-slave mode each nibble of every bank is an input or an output as software configures it.
// - In standalone mode the first and second banks are inputs only and are never driven.
// - In standalone mode the third bank outputs the filtered first-bank inputs.
// - In standalone mode the fourth bank outputs the filtered second-bank inputs.
// - In host-slave mode the capture strobe latches all four banks when capture is enabled.
// - In host-slave mode the update strobe applies all pending outputs at once when update is enabled.
// - In standalone mode a low freeze pin holds the third and fourth bank outputs.
// - In standalone mode the third and fourth banks drive while the drive enable pin is low, else float.
// - In standalone mode a low filter-on pin passes the bank input straight to its output bank.
// - In standalone mode three 4-bit pin groups set the time constants of the three filter groups.
// - In standalone mode, while reset is low, the third and fourth banks output low.
module dual_mode_io_port_pins import gpio_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic               standalone_select_n,
	input  wire bank_type           first_io_bank_in,
	output bank_type                first_io_bank_out,
	output bank_type                first_io_bank_oe,
	input  wire bank_type           second_io_bank_in,
	output bank_type                second_io_bank_out,
	output bank_type                second_io_bank_oe,
	input  wire bank_type           third_io_bank_in,
	output bank_type                third_io_bank_out,
	output bank_type                third_io_bank_oe,
	input  wire bank_type           fourth_io_bank_in,
	output bank_type                fourth_io_bank_out,
	output bank_type                fourth_io_bank_oe,
	input  wire logic               irq_request_n_in,
	output logic                    irq_request_n_out,
	output logic                    irq_request_n_oe,
	input  wire logic               input_capture_strobe,
	input  wire logic               output_freeze_n,
	input  wire logic               output_update_strobe,
	input  wire logic               output_drive_enable_n,
	input  wire logic               first_bank_filter_on,
	input  wire logic               second_bank_filter_on,
	input  wire nibble_type         first_bank_low_filter_const,
	input  wire nibble_type         first_bank_high_filter_const,
	input  wire nibble_type         second_bank_filter_const,
	input  wire logic [`ADDR_W-1:0] avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [3:0]         avs_byteenable,
	input  wire logic [31:0]        avs_writedata,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest,
	output logic                    irq
);
	port_mode_type        mode;
	logic                 host;
	logic                 standalone;
	logic [9:0]           ctrl_q;
	logic [31:0]          pending_q;
	logic [31:0]          active_q;
	logic [31:0]          latch_q;
	logic [31:0]          live_in;
	logic [`IRQ_W-1:0]    status_q;
	logic [`IRQ_W-1:0]    mask_q;
	logic [`IRQ_W-1:0]    irq_set;
	logic [`IRQ_W-1:0]    irq_clr;
	logic [31:0]          rd_mux;
	logic                 accept;
	logic                 wr_ctrl;
	logic                 wr_pend;
	logic                 wr_mask;
	logic                 capture_pulse;
	logic                 update_pulse;
	logic                 capture_fire;
	logic                 update_fire;
	bank_type             first_filt;
	bank_type             second_filt;
	logic [31:0]          dir_oe;

	// The pin is a level chosen by the board, so it is read without a register
	assign mode       = standalone_select_n ? MODE_HOST : MODE_STANDALONE;
	assign host       = (mode == MODE_HOST);
	assign standalone = (mode == MODE_STANDALONE);
	assign live_in    = {fourth_io_bank_in, third_io_bank_in, second_io_bank_in, first_io_bank_in};

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		merge_bytes = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				merge_bytes[b*8 +: 8] = new_v[b*8 +: 8];
		end
	endfunction

	// One direction bit per nibble, expanded to four pin enables each
	function automatic logic [31:0] nibble_enables(input logic [7:0] dir);
		nibble_enables = '0;
		for (int n = 0; n < 8; n++)
			nibble_enables[n*4 +: 4] = {4{dir[n]}};
	endfunction

	strobe_edge u_capture_edge
	(
		.mclk    (mclk),
		.reset_n (reset_n),
		.strobe  (input_capture_strobe),
		.pulse   (capture_pulse)
	);

	strobe_edge u_update_edge
	(
		.mclk    (mclk),
		.reset_n (reset_n),
		.strobe  (output_update_strobe),
		.pulse   (update_pulse)
	);

	bank_integral_filter u_first_filter
	(
		.mclk    (mclk),
		.reset_n (reset_n),
		.sample  (first_io_bank_in),
		.enable  (first_bank_filter_on),
		.tc_low  (first_bank_low_filter_const),
		.tc_high (first_bank_high_filter_const),
		.filt    (first_filt)
	);

	bank_integral_filter u_second_filter
	(
		.mclk    (mclk),
		.reset_n (reset_n),
		.sample  (second_io_bank_in),
		.enable  (second_bank_filter_on),
		.tc_low  (second_bank_filter_const),
		.tc_high (second_bank_filter_const),
		.filt    (second_filt)
	);

	// Bus slave: one wait state per access, so a request is taken while waitrequest is high
	assign accept  = (avs_read | avs_write) & avs_waitrequest;
	assign wr_ctrl = accept & avs_write & (avs_address == `OFS_CTRL);
	assign wr_pend = accept & avs_write & (avs_address == `OFS_OUT_PENDING);
	assign wr_mask = accept & avs_write & (avs_address == `OFS_IRQ_MASK);

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= ~accept;
	end

	always_comb
	begin
		case (avs_address)
			`OFS_CTRL:        rd_mux = {22'h000000, ctrl_q};
			`OFS_OUT_PENDING: rd_mux = pending_q;
			`OFS_OUT_ACTIVE:  rd_mux = active_q;
			`OFS_LIVE_IN:     rd_mux = live_in;
			`OFS_LATCH_IN:    rd_mux = latch_q;
			`OFS_IRQ_STATUS:  rd_mux = {30'h00000000, status_q};
			`OFS_IRQ_MASK:    rd_mux = {30'h00000000, mask_q};
			default:          rd_mux = `WORD_RESET;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			avs_readdata <= `WORD_RESET;
		else if (accept & avs_read)
			avs_readdata <= rd_mux;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			ctrl_q <= `CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= 10'(merge_bytes({22'h000000, ctrl_q}, avs_writedata, avs_byteenable));
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			pending_q <= `WORD_RESET;
		else if (wr_pend)
			pending_q <= merge_bytes(pending_q, avs_writedata, avs_byteenable);
	end

	// Deferred outputs wait for the update strobe; otherwise a write shows at once
	assign update_fire  = host & ctrl_q[`CTRL_UPDATE_EN] & update_pulse;
	assign capture_fire = host & ctrl_q[`CTRL_CAPTURE_EN] & capture_pulse;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			active_q <= `WORD_RESET;
		else if (!ctrl_q[`CTRL_UPDATE_EN])
			active_q <= pending_q;
		else if (update_fire)
			active_q <= pending_q;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			latch_q <= `WORD_RESET;
		else if (capture_fire)
			latch_q <= live_in;
	end

	// Interrupt status: a new event beats a read-clear in the same cycle
	assign irq_set[`IRQ_CAPTURE] = capture_fire;
	assign irq_set[`IRQ_UPDATE]  = update_fire;
	assign irq_clr = {`IRQ_W{accept & avs_read & (avs_address == `OFS_IRQ_STATUS)}};

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			status_q <= `IRQ_RESET;
		else
			status_q <= (status_q & ~irq_clr) | irq_set;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			mask_q <= `IRQ_RESET;
		else if (wr_mask)
			mask_q <= avs_writedata[`IRQ_W-1:0];
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= |(status_q & mask_q);
	end

	// Open drain: only ever drives low; in standalone mode the pin is a tied test input
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			irq_request_n_out <= 1'b0;
			irq_request_n_oe  <= 1'b0;
		end
		else
		begin
			irq_request_n_out <= 1'b0;
			irq_request_n_oe  <= host & (|(status_q & mask_q));
		end
	end

	assign dir_oe = nibble_enables(ctrl_q[`CTRL_DIR_MSB:`CTRL_DIR_LSB]);

	// Input-only banks in standalone mode
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			first_io_bank_out  <= `BANK_RESET;
			first_io_bank_oe   <= `BANK_RESET;
			second_io_bank_out <= `BANK_RESET;
			second_io_bank_oe  <= `BANK_RESET;
		end
		else if (host)
		begin
			first_io_bank_out  <= active_q[7:0];
			first_io_bank_oe   <= dir_oe[7:0];
			second_io_bank_out <= active_q[15:8];
			second_io_bank_oe  <= dir_oe[15:8];
		end
		else
		begin
			first_io_bank_out  <= `BANK_RESET;
			first_io_bank_oe   <= `BANK_RESET;
			second_io_bank_out <= `BANK_RESET;
			second_io_bank_oe  <= `BANK_RESET;
		end
	end

	// Reset clears these to low, which is the standalone reset output level
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			third_io_bank_out  <= `BANK_RESET;
			fourth_io_bank_out <= `BANK_RESET;
		end
		else if (host)
		begin
			third_io_bank_out  <= active_q[23:16];
			fourth_io_bank_out <= active_q[31:24];
		end
		else if (output_freeze_n)
		begin
			third_io_bank_out  <= first_filt;
			fourth_io_bank_out <= second_filt;
		end
		else
		begin
			third_io_bank_out  <= third_io_bank_out;
			fourth_io_bank_out <= fourth_io_bank_out;
		end
	end

	// Host mode comes up with every bank as input; standalone drives the low reset level while the drive enable pin is low
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			third_io_bank_oe  <= standalone ? {8{~output_drive_enable_n}} : `BANK_RESET;
			fourth_io_bank_oe <= standalone ? {8{~output_drive_enable_n}} : `BANK_RESET;
		end
		else if (host)
		begin
			third_io_bank_oe  <= dir_oe[23:16];
			fourth_io_bank_oe <= dir_oe[31:24];
		end
		else
		begin
			third_io_bank_oe  <= {8{~output_drive_enable_n}};
			fourth_io_bank_oe <= {8{~output_drive_enable_n}};
		end
	end

	a_irq_pull_low: assert property (@(posedge mclk) disable iff (!reset_n)
		host && |(status_q & mask_q) |=> irq_request_n_oe && !irq_request_n_out)
		else $error("interrupt pin not pulled low while pending");

	a_irq_release: assert property (@(posedge mclk) disable iff (!reset_n)
		(status_q & mask_q) == 2'h0 |=> !irq_request_n_oe)
		else $error("interrupt pin still driven after clear");

	a_nibble_direction: assert property (@(posedge mclk) disable iff (!reset_n)
		host |=> {fourth_io_bank_oe, third_io_bank_oe, second_io_bank_oe, first_io_bank_oe}
		== nibble_enables($past(ctrl_q[`CTRL_DIR_MSB:`CTRL_DIR_LSB])))
		else $error("bank enables do not follow nibble directions");

	a_inputs_only: assert property (@(posedge mclk) disable iff (!reset_n)
		standalone |=> first_io_bank_oe == 8'h00 && second_io_bank_oe == 8'h00)
		else $error("input bank driven in standalone mode");

	a_filtered_outputs: assert property (@(posedge mclk) disable iff (!reset_n)
		standalone && output_freeze_n
		|=> third_io_bank_out == $past(first_filt) && fourth_io_bank_out == $past(second_filt))
		else $error("output banks do not follow filtered inputs");

	a_freeze_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		standalone && !output_freeze_n |=> $stable(third_io_bank_out) && $stable(fourth_io_bank_out))
		else $error("frozen output banks changed");

	a_drive_enable: assert property (@(posedge mclk) disable iff (!reset_n)
		standalone |=> third_io_bank_oe == {8{!$past(output_drive_enable_n)}}
		&& fourth_io_bank_oe == third_io_bank_oe)
		else $error("output bank enable does not follow drive enable pin");

	a_reset_low: assert property (@(posedge mclk)
		!reset_n |=> third_io_bank_out == 8'h00 && fourth_io_bank_out == 8'h00)
		else $error("output banks not low after reset");

	a_capture_latch: assert property (@(posedge mclk) disable iff (!reset_n)
		capture_fire |=> latch_q == $past(live_in) && status_q[`IRQ_CAPTURE])
		else $error("capture strobe did not latch inputs");

	a_capture_idle: assert property (@(posedge mclk) disable iff (!reset_n)
		!(host && ctrl_q[`CTRL_CAPTURE_EN] && capture_pulse) |=> $stable(latch_q))
		else $error("latched inputs changed without an enabled strobe");

	a_update_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		ctrl_q[`CTRL_UPDATE_EN] && !update_fire |=> $stable(active_q))
		else $error("deferred outputs changed without update strobe");

	c_capture_event: cover property (@(posedge mclk) disable iff (!reset_n) capture_fire);
	c_update_event:  cover property (@(posedge mclk) disable iff (!reset_n) update_fire);
	c_irq_driven:    cover property (@(posedge mclk) disable iff (!reset_n) $rose(irq_request_n_oe));
	c_freeze:        cover property (@(posedge mclk) disable iff (!reset_n)
		standalone && !output_freeze_n ##1 standalone && output_freeze_n);
endmodule

//--- field_model.sv
// Far-side model: board mode strap, field signal levels on the four banks, pulled-up interrupt line.
// Assumes the testbench supplies field levels and the wanted mode; one mclk domain.
module field_model
(
	input  wire logic        host_mode,
	output logic             standalone_select_n,
	input  wire logic [31:0] field,
	input  wire logic [31:0] dev_out,
	input  wire logic [31:0] dev_oe,
	output logic [31:0]      pins,
	input  wire logic        irq_out,
	input  wire logic        irq_oe,
	output logic             irq_pin
);
	assign standalone_select_n = host_mode;
	// A bit driven by the device wins; elsewhere the field drives the wire
	assign pins = (dev_oe & dev_out) | (~dev_oe & field);
	// Test pin is grounded in standalone; in host mode a pull-up holds the released line high
	assign irq_pin = host_mode ? (irq_oe ? irq_out : 1'b1) : 1'b0;
endmodule

//--- gpio_defs.svh
// Constants for the dual-mode I/O port block: register map, fields, resets, timing.
// Assumes a 50 MHz mclk and a byte-addressed Avalon-MM register window.
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define CLK_PERIOD_NS       20
`define FILTER_UNIT_NS      1000
`define FILTER_UNIT_CYCLES  ((`FILTER_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_CNT_W        10

`define ADDR_W              6
`define OFS_CTRL            6'h00
`define OFS_OUT_PENDING     6'h04
`define OFS_OUT_ACTIVE      6'h08
`define OFS_LIVE_IN         6'h0C
`define OFS_LATCH_IN        6'h10
`define OFS_IRQ_STATUS      6'h14
`define OFS_IRQ_MASK        6'h18

`define CTRL_DIR_LSB        0
`define CTRL_DIR_MSB        7
`define CTRL_CAPTURE_EN     8
`define CTRL_UPDATE_EN      9
`define CTRL_RESET          10'h000
`define WORD_RESET          32'h00000000
`define BANK_RESET          8'h00

`define IRQ_W               2
`define IRQ_CAPTURE         0
`define IRQ_UPDATE          1
`define IRQ_RESET           2'h0

`endif

//--- gpio_pkg.sv
// Types shared by the dual-mode I/O port block.
// Assumes nothing beyond a SystemVerilog package scope.
package gpio_pkg;
	typedef logic [7:0] bank_type;
	typedef logic [3:0] nibble_type;
	typedef enum logic {MODE_STANDALONE, MODE_HOST} port_mode_type;
endpackage

//--- strobe_edge.sv
// Rising-edge detector for a strobe pin.
// Assumes the strobe is already synchronous to mclk.
module strobe_edge
(
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic strobe,
	output logic      pulse
);
	logic strobe_q;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			strobe_q <= 1'b0;
		else
			strobe_q <= strobe;
	end

	assign pulse = strobe & ~strobe_q;
endmodule

//--- testbench.sv
// Self-checking bench for the dual-mode I/O port block.
// Assumes the field model resolves the pins; Avalon-MM master tasks in mclk.
`include "gpio_defs.svh"
module testbench import gpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset_n, host_mode, cap_stb, upd_stb, freeze_n, den_n, fon_a, fon_b, rd, wr;
	nibble_type  tc_lo, tc_hi, tc_b;
	logic [31:0] field, wdata, rv;
	logic [5:0]  addr;
	logic [3:0]  ben, bus_be;
	wire  [31:0] pins, dev_out, dev_oe, rdata;
	wire         sel_n, irq_pin, irq_n_out, irq_n_oe, waitreq, irq;
	int          err_count, n_checks;

	field_model field_model_inst (.host_mode(host_mode), .standalone_select_n(sel_n), .field(field),
		.dev_out(dev_out), .dev_oe(dev_oe), .pins(pins), .irq_out(irq_n_out), .irq_oe(irq_n_oe),
		.irq_pin(irq_pin));

	dual_mode_io_port_pins dual_mode_io_port_pins_inst (.mclk(mclk), .reset_n(reset_n),
		.standalone_select_n(sel_n),
		.first_io_bank_in(pins[7:0]), .first_io_bank_out(dev_out[7:0]), .first_io_bank_oe(dev_oe[7:0]),
		.second_io_bank_in(pins[15:8]), .second_io_bank_out(dev_out[15:8]),
		.second_io_bank_oe(dev_oe[15:8]),
		.third_io_bank_in(pins[23:16]), .third_io_bank_out(dev_out[23:16]),
		.third_io_bank_oe(dev_oe[23:16]),
		.fourth_io_bank_in(pins[31:24]), .fourth_io_bank_out(dev_out[31:24]),
		.fourth_io_bank_oe(dev_oe[31:24]),
		.irq_request_n_in(irq_pin), .irq_request_n_out(irq_n_out), .irq_request_n_oe(irq_n_oe),
		.input_capture_strobe(cap_stb), .output_freeze_n(freeze_n), .output_update_strobe(upd_stb),
		.output_drive_enable_n(den_n), .first_bank_filter_on(fon_a), .second_bank_filter_on(fon_b),
		.first_bank_low_filter_const(tc_lo), .first_bank_high_filter_const(tc_hi),
		.second_bank_filter_const(tc_b), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_byteenable(ben), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
		.irq(irq));

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Holds the request until waitrequest is sampled low; read data taken at that edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		ben <= bus_be;
		do
		begin
			@(posedge mclk);
		end
		while (waitreq !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic pulse(input logic upd);
		if (upd)
			upd_stb <= 1'b1;
		else
			cap_stb <= 1'b1;
		@(posedge mclk);
		upd_stb <= 1'b0;
		cap_stb <= 1'b0;
	endtask

	task automatic complete_run;
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge mclk);
		err_count++;
		complete_run();
	end

	initial
	begin
		{reset_n, host_mode, cap_stb, upd_stb, fon_a, fon_b, rd, wr, den_n} = '0;
		freeze_n = 1'b1;
		{tc_lo, tc_hi, tc_b, addr, ben, wdata} = '0;
		bus_be = 4'hF;
		field = 32'hFFFFFFFF;
		err_count = 0;
		n_checks = 0;
		wait_n(2);
		check("reset_out", dev_out[31:16], 32'h00000000);
		check("reset_pins", pins[31:16], 32'h00000000);
		reset_n <= 1'b1;
		field <= 32'h0000C35A;
		wait_n(4);
		check("third_bypass", dev_out[23:16], 32'h0000005A);
		check("fourth_bypass", dev_out[31:24], 32'h000000C3);
		check("input_banks_oe", dev_oe[15:0], 32'h00000000);
		check("drive_on", dev_oe[31:16], 32'h0000FFFF);
		den_n <= 1'b1;
		wait_n(3);
		check("drive_off", dev_oe[31:16], 32'h00000000);
		den_n <= 1'b0;
		freeze_n <= 1'b0;
		field <= 32'h00001234;
		wait_n(4);
		check("frozen", dev_out[31:16], 32'h0000C35A);
		freeze_n <= 1'b1;
		wait_n(4);
		check("unfrozen", dev_out[31:16], 32'h00001234);
		fon_a <= 1'b1;
		fon_b <= 1'b1;
		tc_hi <= 4'h1;
		wait_n(120);
		// Ten-cycle glitch on every bit, far below the 50- and 100-cycle constants
		field <= 32'h0000EDCB;
		wait_n(10);
		field <= 32'h00001234;
		wait_n(120);
		check("glitch", dev_out[31:16], 32'h00001234);
		field <= 32'h0000EDCB;
		wait_n(40);
		check("early", dev_out[31:16], 32'h00001234);
		wait_n(20);
		check("short_const", dev_out[31:16], 32'h0000ED3B);
		wait_n(50);
		check("long_const", dev_out[31:16], 32'h0000EDCB);
		reset_n <= 1'b0;
		wait_n(2);
		check("reset_again", dev_out[31:16], 32'h00000000);
		reset_n <= 1'b1;
		host_mode <= 1'b1;
		fon_a <= 1'b0;
		fon_b <= 1'b0;
		bus(1'b0, 6'h1C, 32'h00000000);
		check("unmapped", rv, 32'h00000000);
		bus(1'b1, `OFS_CTRL, 32'h000000FF);
		bus(1'b1, `OFS_OUT_PENDING, 32'h44332211);
		wait_n(4);
		check("host_out", dev_out, 32'h44332211);
		check("host_oe_all", dev_oe, 32'hFFFFFFFF);
		bus(1'b1, `OFS_CTRL, 32'h00000109);
		wait_n(3);
		check("host_oe_nibble", dev_oe, 32'h0000F00F);
		bus(1'b1, `OFS_IRQ_MASK, 32'h00000003);
		field <= 32'hA1B2C3D4;
		wait_n(2);
		pulse(1'b0);
		field <= 32'h00000000;
		wait_n(3);
		check("irq_line_low", irq_n_oe, 32'h00000001);
		check("irq_out", irq, 32'h00000001);
		check("irq_pin_low", irq_pin, 32'h00000000);
		bus(1'b0, `OFS_LATCH_IN, 32'h00000000);
		check("latched", rv, 32'hA1B223D1);
		bus(1'b0, `OFS_IRQ_STATUS, 32'h00000000);
		check("status_capture", rv, 32'h00000001);
		wait_n(3);
		check("irq_released", irq_n_oe, 32'h00000000);
		check("irq_pin_high", irq_pin, 32'h00000001);
		bus(1'b1, `OFS_CTRL, 32'h000002FF);
		field <= 32'h5A5A5A5A;
		pulse(1'b0);
		bus(1'b0, `OFS_LATCH_IN, 32'h00000000);
		check("capture_off", rv, 32'hA1B223D1);
		bus(1'b1, `OFS_OUT_PENDING, 32'h8899AABB);
		wait_n(3);
		check("pending_held", dev_out, 32'h44332211);
		pulse(1'b1);
		wait_n(3);
		check("updated", dev_out, 32'h8899AABB);
		bus(1'b0, `OFS_OUT_ACTIVE, 32'h00000000);
		check("active_reg", rv, 32'h8899AABB);
		bus(1'b0, `OFS_IRQ_STATUS, 32'h00000000);
		check("status_update", rv[1], 32'h00000001);
		bus(1'b1, `OFS_IRQ_MASK, 32'h00000000);
		pulse(1'b1);
		wait_n(3);
		check("masked_irq", irq, 32'h00000000);
		check("masked_line", irq_n_oe, 32'h00000000);
		bus_be = 4'h2;
		bus(1'b1, `OFS_OUT_PENDING, 32'h00001100);
		bus_be = 4'hF;
		bus(1'b0, `OFS_OUT_PENDING, 32'h00000000);
		check("pending_bytes", rv, 32'h889911BB);
		complete_run();
	end
endmodule
